// *** rtl/obc_option_byte_cfg.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "obc_cfg.svh"

module obc_option_byte_cfg
  import obc_pkg::*;
#(
  parameter logic [12:0] DLY_LONG_CYC = `OBC_DLY_LONG
)(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // non-volatile storage and variant
  input  wire logic [7:0]  i_nv_opt_byte,
  input  wire logic        i_nv_prot_bit,
  input  wire logic        i_flash_variant,
  // programming port
  input  wire logic        i_prog_mode,
  input  wire logic        i_prog_wr,
  input  wire logic [7:0]  i_prog_wdata,
  output logic             o_prog_wr_en,
  output logic [7:0]       o_prog_wdata,
  output logic [7:0]       o_prog_rdata,
  // halt exit
  input  wire logic        i_halt_exit,
  // decoded configuration
  output obc_opt_t         o_opt,
  output obc_rng_onehot_t  o_range_onehot,
  output logic             o_pkg_wide,
  output logic [7:0]       o_unbonded_pad_mask,
  output logic             o_src_resonator,
  output logic             o_src_rc,
  output logic             o_src_external,
  output logic             o_resonator_current_sel,
  output logic             o_pll_enable,
  output logic             o_readout_protect,
  output logic             o_cfg_illegal,
  // reset sequencer
  output logic             o_delay_busy,
  output logic             o_cpu_release
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic obc_opt_t obc_unpack(input logic [7:0] b);
    obc_opt_t o;
    o.package_select_bit     = b[`OBC_PKG_BIT];
    o.reset_delay_select     = b[`OBC_RSTDLY_BIT];
    o.clock_source_type      = obc_src_t'(b[`OBC_TYPE_HI:`OBC_TYPE_LO]);
    o.oscillator_range_field = obc_range_t'(b[`OBC_RANGE_HI:`OBC_RANGE_LO]);
    o.pll_disable            = b[`OBC_PLLOFF_BIT];
    return o;
  endfunction : obc_unpack

  function automatic logic obc_src_is(input obc_src_t t, input obc_src_t want);
    return (t == want);
  endfunction : obc_src_is

  function automatic logic [12:0] obc_delay(input logic sel);
    return sel ? `OBC_DLY_SHORT : DLY_LONG_CYC;
  endfunction : obc_delay

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_DELAY  = 3'b010,
    ST_RUN    = 3'b100
  } obc_state_t;

  obc_state_t state_q;
  obc_opt_t   opt_q;
  logic       prot_q;
  logic       start_q;
  logic       dly_done;
  logic       dly_busy;

  // ----------------------------------------------------------------
  // sample once after reset release
  // ----------------------------------------------------------------
  // later changes in the store are ignored until the next reset
  // single capture
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      opt_q  <= obc_opt_t'(`OBC_BYTE_RST);
      prot_q <= `OBC_PROT_RST;
    end else if (state_q == ST_SAMPLE) begin
      opt_q  <= obc_unpack(i_nv_opt_byte);
      prot_q <= i_nv_prot_bit;
    end
  end

  // halt exit reuses the delay chosen at reset
  // delay at reset and halt exit
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_SAMPLE;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        ST_SAMPLE: begin
          state_q <= ST_DELAY;
          start_q <= 1'b1;
        end
        ST_DELAY: begin
          if (dly_done) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (i_halt_exit) begin
            state_q <= ST_DELAY;
            start_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_SAMPLE;
        end
      endcase
    end
  end

  obc_delay_counter u_dly (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_start   (start_q),
    .i_count   (obc_delay(opt_q.reset_delay_select)),
    .o_busy    (dly_busy),
    .o_done    (dly_done)
  );

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  assign o_opt = opt_q;

  assign o_pkg_wide = opt_q.package_select_bit;

  genvar g;
  generate
    for (g = 0; g < `OBC_PORT_PADS; g++) begin : g_pad
      if (g >= 6) begin : g_hi
        assign o_unbonded_pad_mask[g] = ~opt_q.package_select_bit;
      end else begin : g_lo
        assign o_unbonded_pad_mask[g] = 1'b0;
      end
    end
  endgenerate

  assign o_src_resonator = obc_src_is(opt_q.clock_source_type, OBC_SRC_RESONATOR);
  assign o_src_rc        = obc_src_is(opt_q.clock_source_type, OBC_SRC_RC);
  assign o_src_external  = obc_src_is(opt_q.clock_source_type, OBC_SRC_EXTERNAL);

  assign o_resonator_current_sel = o_src_resonator;

  assign o_range_onehot.low_power_range    =
    (opt_q.oscillator_range_field == OBC_RNG_LOW_POWER);
  assign o_range_onehot.medium_power_range =
    (opt_q.oscillator_range_field == OBC_RNG_MEDIUM_POWER);
  assign o_range_onehot.medium_speed_range =
    (opt_q.oscillator_range_field == OBC_RNG_MEDIUM_SPEED);
  assign o_range_onehot.high_speed_range   =
    (opt_q.oscillator_range_field == OBC_RNG_HIGH_SPEED);

  assign o_pll_enable = ~opt_q.pll_disable;

  assign o_readout_protect = i_flash_variant ? ~prot_q : prot_q;

  // ----------------------------------------------------------------
  // unsupported combinations, reported but not overridden
  // ----------------------------------------------------------------
  logic bad_type;
  logic bad_ext_pll;
  logic bad_rc_pll;
  logic bad_range_pll;

  assign bad_type      = obc_src_is(opt_q.clock_source_type, OBC_SRC_RESERVED);
  assign bad_ext_pll   = o_pll_enable & o_src_external & i_flash_variant;
  assign bad_rc_pll    = o_pll_enable & o_src_rc;
  assign bad_range_pll = o_pll_enable & ~o_range_onehot.medium_power_range;

  assign o_cfg_illegal = bad_type | bad_ext_pll | bad_rc_pll | bad_range_pll;

  assign o_prog_wr_en = i_prog_mode & i_prog_wr & i_flash_variant;
  assign o_prog_wdata = i_prog_wdata;
  assign o_prog_rdata = i_prog_mode ? i_nv_opt_byte : 8'h00;

  assign o_delay_busy  = dly_busy;
  assign o_cpu_release = (state_q == ST_RUN);

endmodule : obc_option_byte_cfg
`default_nettype wire

// *** rtl/obc_cfg.svh ***
`ifndef OBC_CFG_SVH
`define OBC_CFG_SVH

// ----------------------------------------------------------------
// option byte field positions
// ----------------------------------------------------------------
`define OBC_PKG_BIT        7
`define OBC_RSTDLY_BIT     6
`define OBC_TYPE_HI        5
`define OBC_TYPE_LO        4
`define OBC_RANGE_HI       3
`define OBC_RANGE_LO       1
`define OBC_PLLOFF_BIT     0

// ----------------------------------------------------------------
// reset values and delay counts
// ----------------------------------------------------------------
`define OBC_BYTE_RST       8'hFF
`define OBC_PROT_RST       1'h1
`define OBC_DLY_LONG       13'h1000
`define OBC_DLY_SHORT      13'h0100
`define OBC_PORT_PADS      8

`endif

// *** rtl/obc_pkg.sv ***
package obc_pkg;

  typedef enum logic [1:0] {
    OBC_SRC_RESONATOR = 2'h0,
    OBC_SRC_RESERVED  = 2'h1,
    OBC_SRC_RC        = 2'h2,
    OBC_SRC_EXTERNAL  = 2'h3
  } obc_src_t;

  typedef enum logic [2:0] {
    OBC_RNG_LOW_POWER    = 3'h0,
    OBC_RNG_MEDIUM_POWER = 3'h1,
    OBC_RNG_MEDIUM_SPEED = 3'h2,
    OBC_RNG_HIGH_SPEED   = 3'h3
  } obc_range_t;

  typedef struct packed {
    logic       package_select_bit;
    logic       reset_delay_select;
    obc_src_t   clock_source_type;
    obc_range_t oscillator_range_field;
    logic       pll_disable;
  } obc_opt_t;

  typedef struct packed {
    logic low_power_range;
    logic medium_power_range;
    logic medium_speed_range;
    logic high_speed_range;
  } obc_rng_onehot_t;

endpackage : obc_pkg

// *** rtl/obc_delay_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "obc_cfg.svh"

module obc_delay_counter
  import obc_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // control
  input  wire logic        i_start,
  input  wire logic [12:0] i_count,
  // status
  output logic             o_busy,
  output logic             o_done
);

  logic [12:0] cnt_q;
  logic        busy_q;
  logic        done_q;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= 13'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_start) begin
        cnt_q  <= i_count - 13'h0001;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 13'h0000) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 13'h0001;
        end
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;

endmodule : obc_delay_counter
`default_nettype wire

// *** tb/obc_option_byte_cfg_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// option byte decode checker
// ----------------------------------------
module obc_option_byte_cfg_chk
  import obc_pkg::*;
#(
  parameter logic [12:0] DLY_LONG_CYC = 13'h1000
)(
  input wire logic            i_ref_clk,
  input wire logic            i_resetn,
  input wire logic            i_nv_prot_bit,
  input wire logic            i_flash_variant,
  input wire logic            i_prog_mode,
  input wire logic            i_prog_wr,
  input wire logic            i_halt_exit,
  input wire logic            o_prog_wr_en,
  input wire logic [7:0]      o_prog_rdata,
  input wire obc_opt_t        o_opt,
  input wire obc_rng_onehot_t o_range_onehot,
  input wire logic            o_pkg_wide,
  input wire logic [7:0]      o_unbonded_pad_mask,
  input wire logic            o_resonator_current_sel,
  input wire logic            o_pll_enable,
  input wire logic            o_readout_protect,
  input wire logic            o_cfg_illegal,
  input wire logic            o_cpu_release
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_halt;
    i_halt_exit && o_cpu_release;
  endsequence
  pkg_decode_a: assert property (
    o_pkg_wide == o_opt.package_select_bit) else $error("package decode wrong");
  pad_mask_a: assert property (
    o_unbonded_pad_mask == {{2{!o_opt.package_select_bit}}, 6'h00}) else $error("pad mask");
  halt_restart_a: assert property (
    s_halt |=> !o_cpu_release [*2]) else $error("halt exit not restarted");
  reserved_flag_a: assert property (
    o_opt.clock_source_type == OBC_SRC_RESERVED |-> o_cfg_illegal) else $error("reserved");
  res_current_a: assert property (
    o_resonator_current_sel == (o_opt.clock_source_type == OBC_SRC_RESONATOR))
    else $error("current source select");
  mp_onehot_a: assert property (
    o_range_onehot.medium_power_range == (o_opt.oscillator_range_field == OBC_RNG_MEDIUM_POWER))
    else $error("range decode");
  pll_enable_a: assert property (
    o_pll_enable != o_opt.pll_disable) else $error("pll enable");
  prot_polarity_a: assert property (
    o_cpu_release |-> o_readout_protect == (i_flash_variant ^ i_nv_prot_bit))
    else $error("protect polarity");
  prog_gate_a: assert property (
    o_prog_wr_en == (i_prog_mode && i_prog_wr && i_flash_variant)) else $error("prog gate");
  no_readback_a: assert property (
    !i_prog_mode |-> o_prog_rdata == 8'h00) else $error("readback outside prog");
  opt_frozen_a: assert property (
    o_cpu_release |-> ##1 $stable(o_opt)) else $error("option changed in run");
endmodule : obc_option_byte_cfg_chk

bind obc_option_byte_cfg obc_option_byte_cfg_chk #(.DLY_LONG_CYC(DLY_LONG_CYC)) u_chk (
  .i_ref_clk, .i_resetn, .i_nv_prot_bit, .i_flash_variant, .i_prog_mode, .i_prog_wr,
  .i_halt_exit, .o_prog_wr_en, .o_prog_rdata, .o_opt, .o_range_onehot, .o_pkg_wide,
  .o_unbonded_pad_mask, .o_resonator_current_sel, .o_pll_enable, .o_readout_protect,
  .o_cfg_illegal, .o_cpu_release);
`default_nettype wire

// *** tb/obc_nv_store.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// non-volatile option byte cell
// ----------------------------------------
module obc_nv_store (
  input  wire logic       i_ref_clk,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_nv_byte
);
  // blank cells read as all ones
  initial o_nv_byte = 8'hFF;
  always @(posedge i_ref_clk) if (i_wr_en) o_nv_byte <= i_wdata;
endmodule : obc_nv_store
`default_nettype wire

// *** tb/obc_option_byte_cfg_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module obc_option_byte_cfg_tb_top import obc_pkg::*;;
  logic            i_ref_clk, i_resetn, i_flash_variant, i_nv_prot_bit, pr;
  logic            i_prog_mode, i_prog_wr, i_halt_exit, o_prog_wr_en;
  logic [7:0]      i_prog_wdata, nv, o_prog_wdata, o_prog_rdata, o_unbonded_pad_mask, b, eb;
  obc_opt_t        o_opt;
  obc_rng_onehot_t o_range_onehot;
  logic            o_pkg_wide, o_src_resonator, o_src_rc, o_src_external, o_delay_busy;
  logic            o_resonator_current_sel, o_pll_enable, o_readout_protect;
  logic            o_cfg_illegal, o_cpu_release;
  int              bad_count = 0, n_tests = 0, n, dly;
  obc_option_byte_cfg #(.DLY_LONG_CYC(13'h0010)) i_obc_option_byte_cfg (.i_ref_clk,
    .i_resetn, .i_nv_opt_byte(nv), .i_nv_prot_bit, .i_flash_variant, .i_prog_mode,
    .i_prog_wr, .i_prog_wdata, .o_prog_wr_en, .o_prog_wdata, .o_prog_rdata, .i_halt_exit,
    .o_opt, .o_range_onehot, .o_pkg_wide, .o_unbonded_pad_mask, .o_src_resonator,
    .o_src_rc, .o_src_external, .o_resonator_current_sel, .o_pll_enable,
    .o_readout_protect, .o_cfg_illegal, .o_delay_busy, .o_cpu_release);
  obc_nv_store i_obc_nv_store (.i_ref_clk, .i_wr_en(o_prog_wr_en), .i_wdata(o_prog_wdata),
    .o_nv_byte(nv));
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chk_n(input string s, input int e, input int g);
    n_tests++;
    if (g != e) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", s, e, g);
    end
  endtask : chk_n
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // counts edges until the cpu is let go
  task automatic wait_rel(input int e);
    int nb;
    nb = 0;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
      if (o_delay_busy === 1'b1) nb++;
    end while (o_cpu_release !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      bad_count++;
      close_out();
    end else begin
      chk_n("release delay", e, n);
      chk_n("busy cycles", dly, nb);
    end
  endtask : wait_rel
  initial begin
    {i_resetn, i_flash_variant, i_nv_prot_bit, i_prog_mode, i_prog_wr, i_halt_exit} = '0;
    i_prog_wdata = 8'h00;
    eb = 8'hFF;
    void'($urandom(32'hF22A));
    repeat (6) @(posedge i_ref_clk);
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      b[5:4] = 2'(i);
      b[3:1] = {1'b0, 2'(i[1:0] + i[2])};
      if (b[5:4] == 2'h0) b[6] = 1'b0;
      b[0] = !(b[5:4] == 2'h0 && b[3:1] == 3'h1);
      pr = 1'($urandom);
      i_resetn <= 1'b0;
      i_flash_variant <= (i != 7);
      i_nv_prot_bit <= pr;
      @(posedge i_ref_clk);
      i_prog_wr <= 1'b1;
      i_prog_wdata <= ~b;
      @(posedge i_ref_clk);
      i_prog_mode <= 1'b1;
      i_prog_wdata <= b;
      @(posedge i_ref_clk);
      i_prog_wr <= 1'b0;
      if (i != 7) eb = b;
      @(posedge i_ref_clk);
      #1;
      chk("prog rdata", eb, o_prog_rdata);
      @(posedge i_ref_clk);
      i_prog_mode <= 1'b0;
      i_resetn <= 1'b1;
      dly = eb[6] ? 256 : 16;
      wait_rel(dly + 3);
      chk("opt", eb, o_opt);
      chk("pkg", 8'(eb[7]), 8'(o_pkg_wide));
      chk("pads", {~eb[7], ~eb[7], 6'h00}, o_unbonded_pad_mask);
      chk("src", 8'({eb[5:4] == 2'h0, eb[5:4] == 2'h2, eb[5:4] == 2'h3}),
          8'({o_src_resonator, o_src_rc, o_src_external}));
      chk("illegal", 8'(eb[5:4] == 2'h1), 8'(o_cfg_illegal));
      chk("current", 8'(eb[5:4] == 2'h0), 8'(o_resonator_current_sel));
      chk("range", 8'(4'h8 >> eb[3:1]), 8'(o_range_onehot));
      chk("pll", 8'(!eb[0]), 8'(o_pll_enable));
      chk("protect", 8'(i_flash_variant ? !pr : pr), 8'(o_readout_protect));
      @(posedge i_ref_clk);
      i_halt_exit <= 1'b1;
      @(posedge i_ref_clk);
      i_halt_exit <= 1'b0;
      #1;
      chk("halt drop", 8'h00, 8'(o_cpu_release));
      wait_rel(dly + 2);
      $display("test %0d done", i);
    end
    close_out();
  end
endmodule : obc_option_byte_cfg_tb_top
`default_nettype wire
